// File: common/zxd_pkg.sv
// Package for the zero-cross detector logic: register map, field positions and reset values.
// Assumes a 32-bit APB slave with byte addresses and one register per aligned word.
package zxd_pkg;

    // Bus widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;  // zero_cross_control.
    localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h04;  // Sticky event status, read only.
    localparam logic [ADDR_W-1:0] OFF_CLR   = 8'h08;  // Write one to clear, write only.
    localparam logic [ADDR_W-1:0] OFF_IEN   = 8'h0c;  // crossing_irq_enable.
    localparam logic [ADDR_W-1:0] OFF_GATE  = 8'h10;  // irq_control_reg gates.

    // Control register field positions.
    localparam int CTRL_EN   = 7;  // Module enable.
    localparam int CTRL_OUT  = 5;  // zero_cross_output, read only.
    localparam int CTRL_INV  = 4;  // output_invert.
    localparam int CTRL_RISE = 1;  // rise_irq_enable.
    localparam int CTRL_FALL = 0;  // fall_irq_enable.

    // Status, clear and enable share one layout.
    localparam int IRQ_FLAG  = 0;  // crossing_irq_flag.

    // Gate register field positions.
    localparam int GATE_PERI = 1;  // peripheral_irq_gate.
    localparam int GATE_GLOB = 0;  // global_irq_gate.

    // Synchroniser depth and the terminal count of the settle counter.
    localparam int         SYNC_STAGES = 2;
    localparam logic [1:0] SETTLE_CNT  = 2'h2;

    // Control bits held by the block.
    typedef struct packed {
        logic enable;
        logic invert;
        logic rise_en;
        logic fall_en;
    } zxd_ctrl_t;

    // Interrupt gates held by the block.
    typedef struct packed {
        logic irq_en;
        logic peri_gate;
        logic glob_gate;
    } zxd_gate_t;

    // Reset values; enable is loaded from the strap once it has settled.
    localparam zxd_ctrl_t CTRL_RST = '{enable: 1'b0, invert: 1'b0, rise_en: 1'b0, fall_en: 1'b0};
    localparam zxd_gate_t GATE_RST = '{irq_en: 1'b0, peri_gate: 1'b0, glob_gate: 1'b0};

endpackage

// File: logic/zxd_sync.sv
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with one another.
`timescale 1ns/1ps
`default_nettype none
module zxd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);
    import zxd_pkg::*;

    // First stage; only the second stage reads it.
    logic [WIDTH-1:0] meta_q;

    // Both stages clear to zero under reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule
`default_nettype wire

// File: logic/zxd_edge.sv
// Rising and falling edge detector on a synchronous level.
// Assumes the level is already on pclk; pulses last exactly one cycle.
`timescale 1ns/1ps
`default_nettype none
module zxd_edge (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic level_i,
    output var  logic rise_o,
    output var  logic fall_o
);
    import zxd_pkg::*;

    // Level seen one cycle earlier.
    logic prev_q;

    // Track the previous level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level_i;
        end
    end

    // A change in either direction gives one pulse.
    always_comb begin
        rise_o = level_i & ~prev_q;
        fall_o = ~level_i & prev_q;
    end

endmodule
`default_nettype wire

// File: logic/zxd_top.sv
// Digital side of the zero-cross detector with an APB register file.
// Assumes the analog front end drives a sink-active level and a power-up strap
// selects whether the unit starts enabled.
//
// How it works
// - Raw input high means front end sinks.
// - Output follows sink state when not inverted.
// - Invert bit flips the output status.
// - Polarity applies even with module disabled.
// - Rise and fall detectors watch inverted output.
// - Per-direction enables qualify each detector.
// - Qualified edge sets flag, independent of gates.
// - Irq needs flag, enable, peripheral, global gates.
// - Toggling polarity may raise an edge.
// - Set beats a simultaneous clear.
// - Detection and irq keep running in sleep.
// - Strap low makes unit start enabled.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module zxd_top (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [zxd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [zxd_pkg::DATA_W-1:0] pwdata,
    output var  logic [zxd_pkg::DATA_W-1:0] prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire logic                       sink_active_raw,
    input  wire logic                       config_default_off,
    output var  logic                       zero_cross_output,
    output var  logic                       unit_enable,
    output var  logic                       irq
);
    import zxd_pkg::*;

    // Address match, used by both the read and the write decoders.
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] off);
        addr_is = (a == off);
    endfunction

    // Synchronised pin levels.
    logic [1:0]       pins_sync;     // Bit 1 strap, bit 0 sink state.
    logic             sink_lvl;      // Sink active, on pclk.
    logic             strap_lvl;     // Default-off strap, on pclk.

    // Software-visible state.
    zxd_ctrl_t        ctrl_q;        // Control bits.
    zxd_gate_t        gate_q;        // Interrupt enable and gates.
    logic             flag_q;        // Sticky crossing flag.
    logic             out_q;         // Polarity-applied output.

    // Start-up strap capture.
    logic [1:0]       settle_q;      // Cycles since reset release.
    logic             strap_done_q;  // Strap has been applied.

    // Edge detection.
    logic             rise_p;        // Output rose this cycle.
    logic             fall_p;        // Output fell this cycle.
    logic             edge_hit;      // Qualified edge.

    // Bus strobes.
    logic             wr_acc;        // Write completes this edge.
    logic             clr_hit;       // Flag clear requested.
    logic             setup_ph;      // Setup phase of a transfer.
    logic             mapped;        // Address is decoded.

    // Both pins pass two flops before anything reads them.
    zxd_sync #(
        .WIDTH (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .async_i ({config_default_off, sink_active_raw}),
        .sync_o  (pins_sync)
    );

    // Split the synchronised group.
    always_comb begin
        sink_lvl  = pins_sync[0];
        strap_lvl = pins_sync[1];
    end

    // The output is built from the input and the invert bit alone, never from
    // the enable, so the status still tracks polarity while the unit is off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0;
        end else begin
            out_q <= sink_lvl ^ ctrl_q.invert;
        end
    end

    // Edges are taken after inversion, so a polarity write can fire one.
    zxd_edge u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .level_i (out_q),
        .rise_o  (rise_p),
        .fall_o  (fall_p)
    );

    // Each direction passes only with its own enable set.
    always_comb begin
        edge_hit = (rise_p & ctrl_q.rise_en) | (fall_p & ctrl_q.fall_en);
    end

    // Bus phase decoding.
    always_comb begin
        setup_ph = psel & ~penable;
        wr_acc   = psel & penable & pready & pwrite;
        clr_hit  = wr_acc & addr_is(paddr, OFF_CLR) & pwdata[IRQ_FLAG];
    end

    // Decoded addresses; anything else answers with an error.
    always_comb begin
        if (addr_is(paddr, OFF_CTRL)) begin
            mapped = 1'b1;
        end else if (addr_is(paddr, OFF_STAT)) begin
            mapped = 1'b1;
        end else if (addr_is(paddr, OFF_CLR)) begin
            mapped = 1'b1;
        end else if (addr_is(paddr, OFF_IEN)) begin
            mapped = 1'b1;
        end else if (addr_is(paddr, OFF_GATE)) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Count the cycles the strap needs to cross the synchroniser.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_q     <= '0;
            strap_done_q <= 1'b0;
        end else if (settle_q != SETTLE_CNT) begin
            settle_q <= settle_q + 2'h1;
        end else begin
            strap_done_q <= 1'b1;
        end
    end

    // Control register; the enable default comes from the strap once settled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
        end else if (!strap_done_q && settle_q == SETTLE_CNT) begin
            ctrl_q.enable <= ~strap_lvl;
        end else if (wr_acc && addr_is(paddr, OFF_CTRL)) begin
            ctrl_q.enable  <= pwdata[CTRL_EN];
            ctrl_q.invert  <= pwdata[CTRL_INV];
            ctrl_q.rise_en <= pwdata[CTRL_RISE];
            ctrl_q.fall_en <= pwdata[CTRL_FALL];
        end
    end

    // Interrupt enable and the two upstream gates.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q <= GATE_RST;
        end else if (wr_acc && addr_is(paddr, OFF_IEN)) begin
            gate_q.irq_en <= pwdata[IRQ_FLAG];
        end else if (wr_acc && addr_is(paddr, OFF_GATE)) begin
            gate_q.peri_gate <= pwdata[GATE_PERI];
            gate_q.glob_gate <= pwdata[GATE_GLOB];
        end
    end

    // Sticky flag: only software clears it, and a new edge in the same cycle
    // wins so that no crossing is lost while the handler runs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (edge_hit) begin
            flag_q <= 1'b1;
        end else if (clr_hit) begin
            flag_q <= 1'b0;
        end
    end

    // Interrupt output: every gate must be set. Nothing here looks at a
    // low-power state, so the flag and the line work on while asleep.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= flag_q & gate_q.irq_en & gate_q.peri_gate & gate_q.glob_gate;
        end
    end

    // Pin-side copies of the output and the enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_cross_output <= 1'b0;
            unit_enable       <= 1'b0;
        end else begin
            zero_cross_output <= out_q;
            unit_enable       <= ctrl_q.enable;
        end
    end

    // The slave answers in the first access cycle; ready is registered, so
    // it is raised from the setup phase and dropped right after.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~mapped;
        end
    end

    // Read data is captured in the setup phase; write-only and unmapped
    // words read as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_ph && !pwrite) begin
            prdata <= '0;
            if (addr_is(paddr, OFF_CTRL)) begin
                prdata[CTRL_EN]   <= ctrl_q.enable;
                prdata[CTRL_OUT]  <= out_q;
                prdata[CTRL_INV]  <= ctrl_q.invert;
                prdata[CTRL_RISE] <= ctrl_q.rise_en;
                prdata[CTRL_FALL] <= ctrl_q.fall_en;
            end else if (addr_is(paddr, OFF_STAT)) begin
                prdata[IRQ_FLAG] <= flag_q;
            end else if (addr_is(paddr, OFF_IEN)) begin
                prdata[IRQ_FLAG] <= gate_q.irq_en;
            end else if (addr_is(paddr, OFF_GATE)) begin
                prdata[GATE_PERI] <= gate_q.peri_gate;
                prdata[GATE_GLOB] <= gate_q.glob_gate;
            end
        end
    end

    // Checks on the block's own behaviour.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A polarity change with a steady input, followed by a detector pulse.
    sequence s_pol_flip;
        $changed(ctrl_q.invert) && $stable(sink_lvl);
    endsequence

    // An enabled edge, then the flag a cycle later.
    sequence s_rise_armed;
        rise_p && ctrl_q.rise_en;
    endsequence

    sequence s_fall_armed;
        fall_p && ctrl_q.fall_en;
    endsequence

    // Only checked once three post-reset samples of the pin are in the
    // pipeline; a pin held high across reset would otherwise look late.
    AST_SYNC_DEPTH: assert property (strap_done_q |->
                                     $past(sink_lvl) == $past(sink_active_raw, 3))
        else $error("Sink level not two flops behind the pin.");

    AST_OUT_POLARITY: assert property (out_q == ($past(sink_lvl) ^ $past(ctrl_q.invert)))
        else $error("Output does not follow sink state and polarity.");

    AST_OUT_WHEN_OFF: assert property (!ctrl_q.enable && $changed(ctrl_q.invert)
                                       && $stable(sink_lvl) |=> $changed(out_q))
        else $error("Polarity ignored while unit disabled.");

    AST_POL_EDGE: assert property (s_pol_flip |=> (rise_p || fall_p))
        else $error("Polarity toggle gave no edge pulse.");

    AST_RISE_SETS: assert property (s_rise_armed |=> flag_q)
        else $error("Enabled rising edge did not set the flag.");

    AST_FALL_SETS: assert property (s_fall_armed |=> flag_q)
        else $error("Enabled falling edge did not set the flag.");

    AST_NO_SPURIOUS: assert property ($rose(flag_q) |-> $past(edge_hit))
        else $error("Flag set without a qualified edge.");

    AST_SET_WINS: assert property (edge_hit && clr_hit |=> flag_q)
        else $error("Clear beat a simultaneous edge.");

    AST_IRQ_GATES: assert property (irq == $past(flag_q && gate_q.irq_en
                                    && gate_q.peri_gate && gate_q.glob_gate))
        else $error("Interrupt line disagrees with flag and gates.");

    AST_STRAP_DEFAULT: assert property ($rose(strap_done_q) |-> ctrl_q.enable == !$past(strap_lvl))
        else $error("Start-up enable does not match the strap.");

endmodule
`default_nettype wire

// File: tb/zxd_wave.sv
// Model of the AC waveform as seen through the analog front end of the pin.
// Assumes the bench commands, on pclk, whether the pin sits above the reference.
`timescale 1ns/1ps
`default_nettype none
module zxd_wave (
    input  wire logic pclk,
    input  wire logic above_ref,
    output var  logic sink_active
);
    // Above the reference the front end sinks; below it, it sources.
    always_ff @(posedge pclk) begin
        sink_active <= above_ref;
    end
endmodule
`default_nettype wire

// File: tb/zxd_top_tb.sv
// Self-checking bench for the zero-cross detector register block.
// Assumes the APB slave answers in the first access cycle, as handed over.
`timescale 1ns/1ps
`default_nettype none
module zxd_top_tb;
    import zxd_pkg::*;
    logic              pclk;       // Bus clock, 4 ns period.
    logic              presetn;    // Active-low reset.
    logic              psel;       // APB select.
    logic              penable;    // APB enable.
    logic              pwrite;     // APB direction.
    logic [ADDR_W-1:0] paddr;      // APB address.
    logic [DATA_W-1:0] pwdata;     // APB write data.
    logic [DATA_W-1:0] prdata;     // APB read data.
    logic              pready;     // APB ready.
    logic              pslverr;    // APB error.
    logic              pin;        // Commanded pin side of the reference.
    logic              sink_raw;   // Front end state from the model.
    logic              strap;      // Power-up default-off strap.
    logic              zc_out;     // Polarity-applied output.
    logic              unit_en;    // Module enable towards the analog side.
    logic              irq;        // Interrupt request.
    int                failures;   // Mismatches seen.
    int                check_count; // Comparisons made.
    logic [DATA_W-1:0] w;          // Random control word.

    zxd_wave WAVE (.pclk(pclk), .above_ref(pin), .sink_active(sink_raw));
    zxd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sink_active_raw(sink_raw),
        .config_default_off(strap), .zero_cross_output(zc_out),
        .unit_enable(unit_en), .irq(irq));

    // Free-running clock.
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Builds a control word; the output bit only matters on reads.
    function automatic logic [31:0] ctl(logic en, logic o, logic inv, logic r, logic f);
        return {24'h0, en, 1'b0, o, inv, 2'b00, r, f};
    endfunction

    // The request leaves the block only when all three gates agree with the flag.
    function automatic logic exp_irq(logic flag, logic [2:0] g);
        return flag & (&g);
    endfunction

    task automatic results();
        $display("counts: %0d checks, %0d failures", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer, entered just after a rising edge with penable low; hold
    // keeps psel for a back-to-back setup, otherwise the bus idles for one edge,
    // so no signal is assigned twice in one time step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input bit hold, output logic [31:0] r, output logic e);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            failures++;
            results();
        end
        r = prdata;
        e = pslverr;
        penable <= 1'b0;
        if (!hold) begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit hold);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, hold, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, 1'b0, r, e);
        check(r, exp, "read data");
        check({31'h0, e}, {31'h0, eexp}, "slave error");
    endtask

    // Wave model, sync, edge, flag and irq stages take six edges in all; six leaves no margin.
    task automatic settle();
        repeat (6) @(posedge pclk);
    endtask

    task automatic do_reset(input logic s);
        presetn <= 1'b0;
        strap   <= s;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        settle();
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pin = 1'b0;
        strap = 1'b0;
        failures = 0;
        check_count = 0;
        void'($urandom(32'h7547));
        @(posedge pclk);
        // Reset defaults, refused places and the strap-enabled start.
        do_reset(1'b0);
        check(unit_en, 1'b1, "unit enable");
        rd(OFF_CTRL, ctl(1, 0, 0, 0, 0), 1'b0);
        rd(OFF_STAT, 32'h0, 1'b0);
        rd(OFF_IEN, 32'h0, 1'b0);
        rd(OFF_GATE, 32'h0, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        wr(OFF_STAT, 32'h1, 0);
        rd(OFF_STAT, 32'h0, 1'b0);
        rd(OFF_CLR, 32'h0, 1'b0);
        $display("test reset done");
        // Random control words and pin levels, enable bit random too.
        for (int i = 0; i < 8; i++) begin
            w = $urandom();
            pin <= 1'($urandom());
            wr(OFF_CTRL, w, 0);
            settle();
            rd(OFF_CTRL, ctl(w[7], pin ^ w[4], w[4], w[1], w[0]), 1'b0);
            check(zc_out, pin ^ w[4], "output");
            wr(OFF_CLR, 32'h1, 0);
        end
        $display("test polarity done");
        // Every combination of the two direction enables, gates all closed.
        pin <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(OFF_CTRL, ctl(1, 0, 0, k[1], k[0]), 0);
            settle();
            wr(OFF_CLR, 32'h1, 0);
            pin <= 1'b1;
            settle();
            rd(OFF_STAT, {31'h0, k[1]}, 1'b0);
            check(irq, 1'b0, "irq closed");
            wr(OFF_CLR, 32'h1, 0);
            pin <= 1'b0;
            settle();
            rd(OFF_STAT, {31'h0, k[0]}, 1'b0);
            wr(OFF_CLR, 32'h1, 0);
        end
        $display("test edges done");
        // Flag stays sticky while every gate combination is tried.
        wr(OFF_CTRL, ctl(1, 0, 0, 1, 0), 0);
        pin <= 1'b1;
        settle();
        for (int g = 0; g < 8; g++) begin
            wr(OFF_IEN, {31'h0, g[2]}, 0);
            wr(OFF_GATE, {30'h0, g[1:0]}, 0);
            settle();
            check(irq, exp_irq(1'b1, g[2:0]), "irq gating");
        end
        rd(OFF_STAT, 32'h1, 1'b0);
        wr(OFF_CLR, 32'h1, 0);
        settle();
        rd(OFF_STAT, 32'h0, 1'b0);
        check(irq, 1'b0, "irq cleared");
        $display("test gates done");
        // Polarity toggles with the unit off, then one lands on the clear edge.
        wr(OFF_CTRL, ctl(0, 0, 1, 1, 1), 0);
        settle();
        rd(OFF_STAT, 32'h1, 1'b0);
        wr(OFF_CLR, 32'h1, 0);
        settle();
        rd(OFF_STAT, 32'h0, 1'b0);
        wr(OFF_CTRL, ctl(0, 0, 0, 1, 1), 1);
        wr(OFF_CLR, 32'h1, 0);
        rd(OFF_STAT, 32'h1, 1'b0);
        check(irq, 1'b1, "irq set");
        $display("test set wins done");
        // A second reset with the strap set starts the unit off.
        do_reset(1'b1);
        check(unit_en, 1'b0, "unit enable");
        rd(OFF_CTRL, ctl(0, 1, 0, 0, 0), 1'b0);
        wr(OFF_CTRL, ctl(1, 0, 0, 0, 0), 0);
        settle();
        check(unit_en, 1'b1, "unit enable");
        $display("test strap done");
        results();
    end
endmodule
`default_nettype wire
